// >>> design/mdrm_arbiter.sv
// Priority arbiter of one controller: highest level, then lowest index
`timescale 1ns/1ps
module mdrm_arbiter #(
  parameter int N     = 7,
  parameter int IDX_W = 3
) (
  input  wire logic [N-1:0]     pend,
  input  wire logic [1:0]       prio [N],
  output logic                  grant_valid,
  output logic [IDX_W-1:0]      grant_idx
);
  if (N > 2 ** IDX_W) begin : g_chk
    $error("Index width too small for channel count");
  end

  logic [1:0] best_prio;

  // Strictly greater replaces, so an equal level keeps the lower index
  always_comb begin
    grant_valid = 1'b0;
    grant_idx   = '0;
    best_prio   = 2'h0;
    for (int i = 0; i < N; i++) begin
      if (pend[i] && (!grant_valid || prio[i] > best_prio)) begin
        grant_valid = 1'b1;
        grant_idx   = IDX_W'(i);
        best_prio   = prio[i];
      end
    end
  end
endmodule : mdrm_arbiter

// >>> design/mdrm_pkg.sv
// Shared constants, types and helpers of the multichannel transfer subsystem
package mdrm_pkg;
  localparam int NUM_CTRL    = 2;
  localparam int CH_PER_CTRL = 7;
  localparam int NUM_CH      = NUM_CTRL * CH_PER_CTRL;
  localparam int IDX_W       = 3;
  localparam int NUM_REQ     = 32;
  localparam int REQ_SEL_W   = 5;
  localparam int NUM_TRIG    = 8;
  localparam int TRIG_SEL_W  = 3;
  localparam int CNT_W       = 17;
  localparam int MAX_COUNT   = 65536;
  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 32;

  // Software priority levels
  localparam logic [1:0] PRIO_LOW   = 2'h0;
  localparam logic [1:0] PRIO_MED   = 2'h1;
  localparam logic [1:0] PRIO_HIGH  = 2'h2;
  localparam logic [1:0] PRIO_VHIGH = 2'h3;

  // Item widths
  typedef enum logic [1:0] {SZ_BYTE, SZ_HALF, SZ_WORD, SZ_RSVD} mdrm_size_type;

  // Per-channel configuration, held stable while the channel is enabled
  typedef struct packed {
    logic                  enable;
    logic                  circular;
    logic                  src_periph;
    logic                  dst_periph;
    logic [1:0]            prio;
    mdrm_size_type         src_size;
    mdrm_size_type         dst_size;
    logic                  src_inc;
    logic                  dst_inc;
    logic                  trig_en;
    logic [TRIG_SEL_W-1:0] trig_sel;
    logic [REQ_SEL_W-1:0]  req_sel;
    logic [CNT_W-1:0]      count;
    logic [ADDR_W-1:0]     src_addr;
    logic [ADDR_W-1:0]     dst_addr;
  } mdrm_cfg_type;

  // Event flags of one channel
  typedef struct packed {
    logic error;
    logic complete;
    logic half;
  } mdrm_flag_type;

  // System bus master request and response
  typedef struct packed {
    logic              req;
    logic              we;
    mdrm_size_type     size;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } mdrm_bus_req_type;

  typedef struct packed {
    logic              ack;
    logic              err;
    logic [DATA_W-1:0] rdata;
  } mdrm_bus_rsp_type;

  localparam mdrm_bus_req_type BUS_IDLE = '0;

  // Address step of one item
  function automatic logic [ADDR_W-1:0] step_of(input mdrm_size_type s);
    unique case (s)
      SZ_BYTE: step_of = 32'h1;
      SZ_HALF: step_of = 32'h2;
      default: step_of = 32'h4;
    endcase
  endfunction : step_of

  // Truncate or zero-extend data to an item width
  function automatic logic [DATA_W-1:0] fit_data(input logic [DATA_W-1:0] d,
                                                 input mdrm_size_type s);
    unique case (s)
      SZ_BYTE: fit_data = d & 32'h0000_00FF;
      SZ_HALF: fit_data = d & 32'h0000_FFFF;
      default: fit_data = d;
    endcase
  endfunction : fit_data
endpackage : mdrm_pkg

// >>> design/mdrm_top.sv
// Two seven-channel transfer controllers fed by a request router
//
// Function
// - Fourteen channels, seven in each controller.
// - Any peripheral request routes to any channel.
// - Hardware trigger may start channel requests.
// - Four software priority levels per channel.
// - Equal priority: lower channel index wins.
// - Independent item widths, data truncated or zero-extended per item.
// - Circular mode restarts after count completes.
// - Half, complete, error flags ORed per channel.
// - All four transfer directions supported.
// - Any bus address as source or destination.
// - Item count programmable up to 65536.
// - Transfers run without processor involvement.
`timescale 1ns/1ps
module mdrm_top #(
  parameter int NUM_REQ  = mdrm_pkg::NUM_REQ,
  parameter int NUM_TRIG = mdrm_pkg::NUM_TRIG
) (
  input  wire logic                        CLOCK,
  input  wire logic                        RST,
  input  wire mdrm_pkg::mdrm_cfg_type      CH_CFG     [mdrm_pkg::NUM_CH],
  input  wire mdrm_pkg::mdrm_flag_type     CH_FLAG_CLR[mdrm_pkg::NUM_CH],
  input  wire logic [NUM_REQ-1:0]          PERIPH_REQ,
  input  wire logic [NUM_TRIG-1:0]         TRIG_IN,
  input  wire mdrm_pkg::mdrm_bus_rsp_type  BUS_IN     [mdrm_pkg::NUM_CTRL],
  output mdrm_pkg::mdrm_bus_req_type       BUS_OUT    [mdrm_pkg::NUM_CTRL],
  output mdrm_pkg::mdrm_flag_type          CH_FLAGS   [mdrm_pkg::NUM_CH],
  output logic [mdrm_pkg::NUM_CH-1:0]      CH_IRQ,
  output logic [mdrm_pkg::NUM_CH-1:0]      CH_BUSY,
  output logic [mdrm_pkg::NUM_CH-1:0]      CH_REQ_ACK,
  output logic [mdrm_pkg::CNT_W-1:0]       CH_REMAIN  [mdrm_pkg::NUM_CH]
);
  localparam int CPC   = mdrm_pkg::CH_PER_CTRL;
  localparam int IW    = mdrm_pkg::IDX_W;
  localparam int AW    = mdrm_pkg::ADDR_W;
  localparam int CW    = mdrm_pkg::CNT_W;

  if (NUM_REQ > 2 ** mdrm_pkg::REQ_SEL_W || NUM_TRIG > 2 ** mdrm_pkg::TRIG_SEL_W) begin : g_chk
    $error("Request or trigger count exceeds selector width");
  end
  if (mdrm_pkg::MAX_COUNT >= 2 ** CW) begin : g_chk_cnt
    $error("Count width cannot hold the largest item count");
  end

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} mdrm_state_type;

  // Trigger edge detection, shared by all channels
  logic [NUM_TRIG-1:0] trig_prev_r;
  logic [NUM_TRIG-1:0] trig_rise;

  always_ff @(posedge CLOCK or posedge RST) begin
    if (RST) begin
      trig_prev_r <= '0;
    end else begin
      trig_prev_r <= TRIG_IN;
    end
  end
  assign trig_rise = TRIG_IN & ~trig_prev_r;

  for (genvar g = 0; g < mdrm_pkg::NUM_CTRL; g++) begin : g_ctrl
    mdrm_state_type          state_r;
    logic [IW-1:0]           ch_r;
    mdrm_pkg::mdrm_bus_req_type bus_r;
    logic [CPC-1:0]          active_r;
    logic [CPC-1:0]          en_prev_r;
    logic [CPC-1:0]          trig_pend_r;
    logic [CW-1:0]           cnt_r   [CPC];
    logic [AW-1:0]           src_r   [CPC];
    logic [AW-1:0]           dst_r   [CPC];
    mdrm_pkg::mdrm_flag_type flag_r  [CPC];
    logic [CPC-1:0]          pend;
    logic [CPC-1:0]          done_vec;
    logic [CPC-1:0]          err_vec;
    logic [1:0]              prio    [CPC];
    logic                    gnt_valid;
    logic [IW-1:0]           gnt_idx;
    mdrm_pkg::mdrm_cfg_type  ccfg;

    // Router: each channel picks a peripheral line or its trigger
    for (genvar j = 0; j < CPC; j++) begin : g_req
      mdrm_pkg::mdrm_cfg_type cfg;
      logic                   needs_req;
      logic                   req_ok;
      assign cfg       = CH_CFG[g*CPC+j];
      assign needs_req = cfg.src_periph | cfg.dst_periph;
      assign req_ok    = cfg.trig_en ? trig_pend_r[j]
                                     : PERIPH_REQ[cfg.req_sel];
      // Memory to memory needs no request and runs item after item, one idle bus cycle apart
      assign pend[j]   = active_r[j] && (cnt_r[j] != '0) && (!needs_req || req_ok);
      assign prio[j]   = cfg.prio;
      assign done_vec[j] = (state_r == ST_WRITE) && BUS_IN[g].ack && !BUS_IN[g].err
                           && (ch_r == IW'(j));
      assign err_vec[j]  = (state_r != ST_IDLE) && BUS_IN[g].err && (ch_r == IW'(j));
      assign CH_FLAGS[g*CPC+j]   = flag_r[j];
      assign CH_IRQ[g*CPC+j]     = flag_r[j].half | flag_r[j].complete | flag_r[j].error;
      assign CH_BUSY[g*CPC+j]    = active_r[j];
      assign CH_REQ_ACK[g*CPC+j] = done_vec[j];
      assign CH_REMAIN[g*CPC+j]  = cnt_r[j];
    end

    mdrm_arbiter #(
      .N     (CPC),
      .IDX_W (IW)
    ) u_arb (
      .pend        (pend),
      .prio        (prio),
      .grant_valid (gnt_valid),
      .grant_idx   (gnt_idx)
    );

    assign ccfg       = CH_CFG[g*CPC+int'(ch_r)];
    assign BUS_OUT[g] = bus_r;

    // Item engine: one read at source width, one write at destination width
    always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
        state_r <= ST_IDLE;
        ch_r    <= '0;
        bus_r   <= mdrm_pkg::BUS_IDLE;
      end else begin
        unique case (state_r)
          ST_IDLE: begin
            if (gnt_valid) begin
              ch_r       <= gnt_idx;
              state_r    <= ST_READ;
              bus_r.req  <= 1'b1;
              bus_r.we   <= 1'b0;
              bus_r.size <= CH_CFG[g*CPC+int'(gnt_idx)].src_size;
              bus_r.addr <= src_r[gnt_idx];
            end
          end
          ST_READ: begin
            if (BUS_IN[g].err) begin
              state_r <= ST_IDLE;
              bus_r   <= mdrm_pkg::BUS_IDLE;
            end else if (BUS_IN[g].ack) begin
              // Wider writes zero-extend, narrower writes keep the low part
              state_r     <= ST_WRITE;
              bus_r.we    <= 1'b1;
              bus_r.size  <= ccfg.dst_size;
              bus_r.addr  <= dst_r[ch_r];
              bus_r.wdata <= mdrm_pkg::fit_data(
                               mdrm_pkg::fit_data(BUS_IN[g].rdata, ccfg.src_size),
                               ccfg.dst_size);
            end
          end
          ST_WRITE: begin
            if (BUS_IN[g].ack || BUS_IN[g].err) begin
              state_r <= ST_IDLE;
              bus_r   <= mdrm_pkg::BUS_IDLE;
            end
          end
          default: begin
            state_r <= ST_IDLE;
            bus_r   <= mdrm_pkg::BUS_IDLE;
          end
        endcase
      end
    end

    // Channel state: arming, address walk, count, flags, trigger latch
    always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
        active_r    <= '0;
        en_prev_r   <= '0;
        trig_pend_r <= '0;
        for (int j = 0; j < CPC; j++) begin
          cnt_r[j]  <= '0;
          src_r[j]  <= '0;
          dst_r[j]  <= '0;
          flag_r[j] <= '0;
        end
      end else begin
        for (int j = 0; j < CPC; j++) begin
          automatic mdrm_pkg::mdrm_cfg_type  cf   = CH_CFG[g*CPC+j];
          automatic mdrm_pkg::mdrm_flag_type clr  = CH_FLAG_CLR[g*CPC+j];
          automatic mdrm_pkg::mdrm_flag_type set  = '0;
          automatic logic [CW-1:0]           cnxt = cnt_r[j] - CW'(1);
          en_prev_r[j] <= cf.enable;
          if (cf.enable && !en_prev_r[j]) begin
            // Rising enable loads the programmed transfer
            active_r[j] <= 1'b1;
            cnt_r[j]    <= cf.count;
            src_r[j]    <= cf.src_addr;
            dst_r[j]    <= cf.dst_addr;
          end else if (!cf.enable) begin
            active_r[j] <= 1'b0;
          end else if (err_vec[j]) begin
            active_r[j] <= 1'b0;
            set.error    = 1'b1;
          end else if (done_vec[j]) begin
            set.half     = (cnxt == (cf.count >> 1));
            if (cnxt == '0) begin
              set.complete = 1'b1;
              if (cf.circular) begin
                cnt_r[j] <= cf.count;
                src_r[j] <= cf.src_addr;
                dst_r[j] <= cf.dst_addr;
              end else begin
                cnt_r[j]    <= '0;
                active_r[j] <= 1'b0;
              end
            end else begin
              cnt_r[j] <= cnxt;
              if (cf.src_inc) begin
                src_r[j] <= src_r[j] + mdrm_pkg::step_of(cf.src_size);
              end
              if (cf.dst_inc) begin
                dst_r[j] <= dst_r[j] + mdrm_pkg::step_of(cf.dst_size);
              end
            end
          end
          // Hardware set wins over a clear in the same cycle
          flag_r[j] <= (flag_r[j] & ~clr) | set;
          // One item per trigger edge; a new edge wins over consumption
          if (cf.enable && cf.trig_en && trig_rise[cf.trig_sel]) begin
            trig_pend_r[j] <= 1'b1;
          end else if (done_vec[j] || !cf.enable) begin
            trig_pend_r[j] <= 1'b0;
          end
        end
      end
    end
  end
endmodule : mdrm_top

// >>> tb/mdrm_bus_model.sv
// System bus responder for both controllers; each byte reads back its own address
`timescale 1ns/1ps
module mdrm_bus_model (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic [3:0]                 dly,
  input  wire mdrm_pkg::mdrm_bus_req_type bus_req [mdrm_pkg::NUM_CTRL],
  output mdrm_pkg::mdrm_bus_rsp_type      bus_rsp [mdrm_pkg::NUM_CTRL]
);
  int          wait_r  [2];
  int          n_wr    [2];
  logic [31:0] last_wa [2];
  logic [31:0] last_wd [2];
  // Answer after dly idle cycles; top byte EE is a faulting region
  always_ff @(posedge clk or posedge rst) begin
    for (int c = 0; c < 2; c++) begin
      if (rst) begin
        bus_rsp[c] <= '0;
        wait_r[c]  <= 0;
        n_wr[c]    <= 0;
      end else begin
        bus_rsp[c].ack   <= 1'b0;
        bus_rsp[c].err   <= 1'b0;
        bus_rsp[c].rdata <= ~bus_rsp[c].rdata; // Data is not held outside an answer
        if (bus_req[c].req && !bus_rsp[c].ack && !bus_rsp[c].err) begin
          wait_r[c] <= (wait_r[c] < dly) ? wait_r[c] + 1 : 0;
          if (wait_r[c] >= dly) begin
            bus_rsp[c].err   <= (bus_req[c].addr[31:24] == 8'hEE);
            bus_rsp[c].ack   <= (bus_req[c].addr[31:24] != 8'hEE);
            bus_rsp[c].rdata <= {bus_req[c].addr[7:0] + 8'h3, bus_req[c].addr[7:0] + 8'h2,
                                 bus_req[c].addr[7:0] + 8'h1, bus_req[c].addr[7:0]};
            if (bus_req[c].we && bus_req[c].addr[31:24] != 8'hEE) begin
              n_wr[c]    <= n_wr[c] + 1;
              last_wa[c] <= bus_req[c].addr;
              last_wd[c] <= bus_req[c].wdata;
            end
          end
        end
      end
    end
  end
endmodule : mdrm_bus_model

// >>> tb/mdrm_props.sv
// Concurrent checks on the ports of the transfer subsystem
`timescale 1ns/1ps
module mdrm_props #(
  parameter int NUM_REQ  = 32,
  parameter int NUM_TRIG = 8
) (
  input wire logic                        CLOCK,
  input wire logic                        RST,
  input wire mdrm_pkg::mdrm_cfg_type      CH_CFG    [mdrm_pkg::NUM_CH],
  input wire mdrm_pkg::mdrm_bus_rsp_type  BUS_IN    [mdrm_pkg::NUM_CTRL],
  input wire mdrm_pkg::mdrm_bus_req_type  BUS_OUT   [mdrm_pkg::NUM_CTRL],
  input wire mdrm_pkg::mdrm_flag_type     CH_FLAGS  [mdrm_pkg::NUM_CH],
  input wire logic [mdrm_pkg::NUM_CH-1:0] CH_IRQ,
  input wire logic [mdrm_pkg::NUM_CH-1:0] CH_BUSY,
  input wire logic [mdrm_pkg::NUM_CH-1:0] CH_REQ_ACK,
  input wire logic [mdrm_pkg::CNT_W-1:0]  CH_REMAIN [mdrm_pkg::NUM_CH]
);
  // Channel 0 on the first controller is the watched lane
  wire mdrm_pkg::mdrm_bus_req_type bo = BUS_OUT[0];
  wire mdrm_pkg::mdrm_bus_rsp_type bi = BUS_IN[0];
  wire mdrm_pkg::mdrm_flag_type    f0 = CH_FLAGS[0];
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  a_irq_or_flags: assert property (CH_IRQ[0] == |f0)
    else $error("irq differs from flag or");
  a_remain_bound: assert property (CH_REMAIN[0] <= 17'h10000)
    else $error("remaining count above limit");
  a_req_holds: assert property (bo.req && !bi.ack && !bi.err |=> $stable(bo))
    else $error("bus request changed before answer");
  a_read_then_write: assert property (bo.req && !bo.we && bi.ack |=> bo.req && bo.we)
    else $error("read not followed by write");
  a_gap_after_write: assert property (bo.req && bo.we && (bi.ack || bi.err) |=> !bo.req)
    else $error("no idle cycle after write");
  a_ack_on_write: assert property (CH_REQ_ACK[0] |-> bo.req && bo.we && bi.ack)
    else $error("request ack outside write ack");
  a_stop_at_zero: assert property ($rose(f0.complete) && !CH_CFG[0].circular
    |-> ##[0:1] (!CH_BUSY[0] && CH_REMAIN[0] == 17'h0))
    else $error("channel still armed after last item");
  a_circ_reload: assert property ($rose(f0.complete) && CH_CFG[0].circular
    |-> ##[0:1] (CH_BUSY[0] && CH_REMAIN[0] == CH_CFG[0].count))
    else $error("circular channel not reloaded");
  a_half_mark: assert property ($rose(f0.half) && !f0.complete
    |-> ##[0:1] (CH_REMAIN[0] == (CH_CFG[0].count >> 1)))
    else $error("half flag away from midpoint");
endmodule : mdrm_props

// >>> tb/mdrm_top_tb.sv
// Self-checking bench of the transfer subsystem
`timescale 1ns/1ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin error_cnt++; $display("mismatch t=%0t got=%0h exp=%0h", $time, a, e); end end
module mdrm_top_tb;
  typedef struct {
    logic [1:0]  ss;
    logic [1:0]  ds;
    logic [31:0] sa;
    logic [16:0] n;
    logic [3:0]  d;
    logic [31:0] wd;
    logic [31:0] wa;
  } mdrm_row_type;
  logic                       clk  = 1'b0;
  logic                       rst  = 1'b1;
  logic [31:0]                preq = 32'h0;
  logic [7:0]                 trig = 8'h0;
  logic [3:0]                 dly  = 4'h0;
  mdrm_pkg::mdrm_cfg_type     cfg   [14];
  mdrm_pkg::mdrm_flag_type    clr   [14];
  mdrm_pkg::mdrm_flag_type    flg   [14];
  logic [16:0]                rem   [14];
  mdrm_pkg::mdrm_bus_rsp_type b_in  [2];
  mdrm_pkg::mdrm_bus_req_type b_out [2];
  logic [13:0]                irq;
  logic [13:0]                busy;
  logic [13:0]                rack;
  int                         error_cnt = 0;
  int                         n_checks  = 0;
  int                         n0;
  // Last item of each row: source bytes read back their address, then fit to both widths
  mdrm_row_type rows [5] = '{'{2'h0, 2'h2, 32'h13, 17'h3, 4'h0, 32'h15, 32'h208},
    '{2'h2, 2'h0, 32'h40, 17'h2, 4'h2, 32'h44, 32'h201},
    '{2'h1, 2'h1, 32'h22, 17'h4, 4'h0, 32'h2928, 32'h206},
    '{2'h2, 2'h2, 32'h10, 17'h1, 4'h3, 32'h13121110, 32'h200},
    '{2'h0, 2'h1, 32'h7, 17'h2, 4'h1, 32'h8, 32'h202}};
  // Pairs: a, b, prio a, prio b, expected winner
  int races [4][5] = '{'{1, 2, 0, 2, 2}, '{3, 5, 1, 1, 3}, '{8, 10, 3, 1, 8}, '{11, 12, 0, 0, 11}};

  mdrm_top i_mdrm_top (.CLOCK(clk), .RST(rst), .CH_CFG(cfg), .CH_FLAG_CLR(clr),
    .PERIPH_REQ(preq), .TRIG_IN(trig), .BUS_IN(b_in), .BUS_OUT(b_out), .CH_FLAGS(flg),
    .CH_IRQ(irq), .CH_BUSY(busy), .CH_REQ_ACK(rack), .CH_REMAIN(rem));
  mdrm_bus_model i_mdrm_bus_model (.clk(clk), .rst(rst), .dly(dly), .bus_req(b_out),
    .bus_rsp(b_in));

  initial forever #5 clk = ~clk;

  // Destination starts at word-aligned 200h; the source address is used as given
  function automatic mdrm_pkg::mdrm_cfg_type mk(input logic [1:0] ss, ds,
      input logic [31:0] sa, input logic [16:0] n, input logic [1:0] pr, input logic [4:0] rs);
    mk          = '0;
    mk.src_size = mdrm_pkg::mdrm_size_type'(ss);
    mk.dst_size = mdrm_pkg::mdrm_size_type'(ds);
    mk.src_addr = sa;
    mk.dst_addr = 32'h200;
    mk.count    = n;
    mk.prio     = pr;
    mk.req_sel  = rs;
    mk.src_inc  = 1'b1;
    mk.dst_inc  = 1'b1;
  endfunction : mk

  // Clear flags, then raise enable one cycle later so the channel sees a fresh start
  task automatic arm(input int c, input mdrm_pkg::mdrm_cfg_type cf);
    cfg[c] = cf;
    clr[c] = 3'h7;
    @(negedge clk);
    clr[c]        = 3'h0;
    cfg[c].enable = 1'b1;
  endtask : arm

  task automatic wait_done(input int c);
    for (int k = 0; k < 300 && !(flg[c].complete | flg[c].error); k++) @(negedge clk);
    repeat (2) @(negedge clk);
  endtask : wait_done

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    foreach (cfg[i]) begin
      cfg[i] = '0;
      clr[i] = '0;
    end
    repeat (6) @(negedge clk);
    `CHK({busy, b_out[0].req, irq}, 29'h0)
    rst = 1'b0;
    repeat (2) @(negedge clk);
    // Memory to memory with five of the nine width pairings
    foreach (rows[k]) begin
      dly = rows[k].d;
      n0  = i_mdrm_bus_model.n_wr[0];
      arm(0, mk(rows[k].ss, rows[k].ds, rows[k].sa, rows[k].n, 2'h0, 5'h0));
      wait_done(0);
      `CHK(17'(i_mdrm_bus_model.n_wr[0] - n0), rows[k].n)
      `CHK(i_mdrm_bus_model.last_wd[0], rows[k].wd)
      `CHK(i_mdrm_bus_model.last_wa[0], rows[k].wa)
      `CHK(flg[0], 3'h3)
      `CHK({irq[0], busy[0], rem[0]}, 19'h40000)
    end
    // Two channels pend at once; the grant order shows the arbitration
    foreach (races[r]) begin
      cfg[races[r][0]] = mk(2'h2, 2'h2, 32'h100, 17'h1, 2'(races[r][2]), 5'(races[r][0] + 16));
      cfg[races[r][1]] = mk(2'h2, 2'h2, 32'h100, 17'h1, 2'(races[r][3]), 5'(races[r][1] + 16));
      cfg[races[r][0]].src_periph = 1'b1;
      cfg[races[r][1]].src_periph = 1'b1;
      preq = (32'h1 << (races[r][0] + 16)) | (32'h1 << (races[r][1] + 16));
      cfg[races[r][0]].enable = 1'b1;
      cfg[races[r][1]].enable = 1'b1;
      for (int k = 0; k < 50 && !(rack[races[r][0]] | rack[races[r][1]]); k++) @(negedge clk);
      `CHK(rack[races[r][4]], 1'b1)
      repeat (20) @(negedge clk);
      `CHK({busy[races[r][0]], busy[races[r][1]]}, 2'h0)
      preq = 32'h0;
    end
    // Trigger edges on the second controller, memory to peripheral
    cfg[9]          = mk(2'h2, 2'h2, 32'h80, 17'h2, 2'h0, 5'h0);
    cfg[9].trig_en  = 1'b1;
    cfg[9].trig_sel = 3'h5;
    cfg[9].dst_periph = 1'b1;
    // Peripheral side keeps one fixed address
    cfg[9].dst_inc  = 1'b0;
    cfg[9].enable   = 1'b1;
    for (int p = 0; p < 2; p++) begin
      repeat (3) @(negedge clk);
      trig[5] = 1'b1;
      @(negedge clk);
      trig[5] = 1'b0;
      repeat (15) @(negedge clk);
      `CHK(rem[9], 17'(1 - p))
    end
    `CHK(flg[9].complete, 1'b1)
    `CHK(i_mdrm_bus_model.last_wa[1], 32'h200)
    `CHK(i_mdrm_bus_model.last_wd[1], 32'h87868584)
    // Circular channel stays armed after the count runs out
    cfg[0] = mk(2'h2, 2'h2, 32'h30, 17'h2, 2'h0, 5'h0);
    cfg[0].circular = 1'b1;
    arm(0, cfg[0]);
    wait_done(0);
    `CHK(busy[0], 1'b1)
    // Faulting source address raises the error flag and disarms
    arm(0, mk(2'h2, 2'h2, 32'hEE000000, 17'h2, 2'h0, 5'h0));
    wait_done(0);
    `CHK({flg[0].error, irq[0], busy[0]}, 3'h6)
    // Reset in the middle of a slow transfer
    dly = 4'h6;
    arm(0, mk(2'h2, 2'h2, 32'h10, 17'h4, 2'h0, 5'h0));
    repeat (8) @(negedge clk);
    rst = 1'b1;
    cfg[0].enable = 1'b0;
    @(negedge clk);
    `CHK({busy[0], b_out[0].req, flg[0]}, 5'h0)
    rst = 1'b0;
    repeat (2) @(negedge clk);
    // An enable still high at release arms again; dropped channel 0 stays idle
    `CHK({busy[1], busy[0], b_out[0].req}, 3'h4)
    tally_and_finish();
  end
endmodule : mdrm_top_tb

bind mdrm_top mdrm_props #(.NUM_REQ(NUM_REQ), .NUM_TRIG(NUM_TRIG)) i_mdrm_props (
  .CLOCK(CLOCK), .RST(RST), .CH_CFG(CH_CFG), .BUS_IN(BUS_IN), .BUS_OUT(BUS_OUT),
  .CH_FLAGS(CH_FLAGS), .CH_IRQ(CH_IRQ), .CH_BUSY(CH_BUSY), .CH_REQ_ACK(CH_REQ_ACK),
  .CH_REMAIN(CH_REMAIN));
